/* File: shared/sdiclk_pkg.sv */
// Purpose: Constants and types for the transceiver clock and reset controller
// Assumes: 50 MHz configuration-port clock
// Notes:   Register map offsets are word indices on the plain register port
package sdiclk_pkg;
  localparam int unsigned CLK_HZ          = 50_000_000;
  localparam int unsigned INIT_WAIT_NS    = 500;
  // Least time rounds up
  localparam int unsigned INIT_WAIT_CYC   = (INIT_WAIT_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int unsigned TIMEOUT_CYC     = 5000;
  localparam int unsigned MAX_RETRIES     = 4;
  localparam int unsigned USRRDY_CYC      = 5;

  localparam logic [3:0]  ADDR_CTRL       = 4'h0;
  localparam logic [3:0]  ADDR_RATE       = 4'h1;
  localparam logic [3:0]  ADDR_STATUS     = 4'h2;
  localparam logic [3:0]  ADDR_RETRY      = 4'h3;

  // CTRL fields
  localparam int unsigned CTRL_RX_FULL    = 0;
  localparam int unsigned CTRL_TX_FULL    = 1;
  localparam int unsigned CTRL_RX_SEL     = 2;
  localparam int unsigned CTRL_TX_SEL     = 3;
  localparam int unsigned CTRL_SLOW_GRADE = 4;
  localparam logic [31:0] CTRL_RESET      = 32'h0000_0000;

  // RATE fields: mode 0 SD, 1 HD, 2 3G; mult 0 = 1/1, 1 = 1/1.001
  localparam int unsigned RATE_RX_MODE    = 0;
  localparam int unsigned RATE_TX_MODE    = 2;
  localparam int unsigned RATE_TX_MULT    = 4;

  // Divider codes (power of two exponent)
  localparam logic [2:0]  DIV_BY_2        = 3'h1;
  localparam logic [2:0]  DIV_BY_4        = 3'h2;

  localparam logic [8:0]  DCP_ADDR_RXDIV  = 9'h088;
  localparam logic [1:0]  SEL_SHARED      = 2'h3;
  localparam logic [1:0]  SEL_CHANNEL     = 2'h0;

  typedef enum logic [2:0] {
    ST_POWERUP, ST_ASSERT, ST_WAIT_REF, ST_WAIT_LOCK, ST_WAIT_DONE,
    ST_TIMEOUT, ST_DONE, ST_FAIL
  } sdiclk_init_t;
endpackage

/* File: verilog/sdiclk_ctrl.sv */
// Purpose: Serial clock source, divider and reset coordination for one channel
// Assumes: All inputs synchronous to SYS_CLK except the transceiver status bits
// Notes:   Registers on a plain port; read data one cycle after read strobe
// ============================================================
module sdiclk_ctrl
  import sdiclk_pkg::*;
#(
  parameter int unsigned TIMEOUT = TIMEOUT_CYC,
  parameter int unsigned RETRIES = MAX_RETRIES
) (
  input  wire logic        SYS_CLK,
  input  wire logic        RSTN,
  input  wire logic [3:0]  ADDR,
  input  wire logic [31:0] WDATA,
  input  wire logic        WR,
  input  wire logic        RD,
  output logic      [31:0] RDATA,
  input  wire logic        RX_REFCLK_STABLE,
  input  wire logic        TX_REFCLK_STABLE,
  input  wire logic        SHARED_PLL_LOCK,
  input  wire logic        CHANNEL_PLL_LOCK,
  input  wire logic        RX_RESET_DONE,
  input  wire logic        TX_RESET_DONE,
  input  wire logic        RX_USRCLK,
  input  wire logic        TX_USRCLK,
  input  wire logic        DCP_RDY,
  output logic             SHARED_PLL_RESET,
  output logic             CHANNEL_PLL_RESET,
  output logic             RX_CHAN_RESET,
  output logic             TX_CHAN_RESET,
  output logic             RX_USER_READY,
  output logic             TX_USER_READY,
  output logic [1:0]       RX_PLL_SEL,
  output logic [1:0]       TX_PLL_SEL,
  output logic [2:0]       TX_DIV_SEL,
  output logic             DCP_EN,
  output logic             DCP_WE,
  output logic [8:0]       DCP_ADDR,
  output logic [15:0]      DCP_DI
);
  initial begin
    if (RETRIES < 1 || RETRIES > 255 || TIMEOUT < 2 || TIMEOUT > 65535)
      $error("sdiclk_ctrl: parameter out of range");
  end

  typedef struct packed {
    sdiclk_init_t st;
    logic [15:0]  tmr;
    logic [7:0]   retry;
    logic         pll_rst;
    logic         chan_rst;
    logic         full_req;
  } sdiclk_seq_t;

  typedef struct packed {
    sdiclk_seq_t rx;
    sdiclk_seq_t tx;
    logic [31:0] ctrl;
    logic [31:0] rate;
    logic [31:0] rdata;
    logic [1:0]  rx_sel;
    logic [1:0]  tx_sel;
    logic [2:0]  tx_div;
    logic [1:0]  rx_mode_app;
    logic        dcp_pend;
    logic        dcp_en;
    logic [15:0] dcp_di;
    logic [1:0]  ref_rx_s;
    logic [1:0]  ref_tx_s;
    logic [1:0]  lk_sh_s;
    logic [1:0]  lk_ch_s;
    logic [1:0]  dn_rx_s;
    logic [1:0]  dn_tx_s;
  } sdiclk_state_t;

  sdiclk_state_t s_r, s_nxt;

  // ============================================================
  // Helper functions
  // Divider exponent: 3G and SD use the fast value, HD twice it
  function automatic logic [2:0] div_for(input logic [1:0] mode, input logic chan_pll);
    logic [2:0] d;
    d = (mode == 2'h1) ? DIV_BY_4 : DIV_BY_2;
    // Per-channel PLL runs at half the shared rate
    if (chan_pll)
      d = d - 3'h1;
    return d;
  endfunction

  // One initialization sequencer, shared by receive and transmit
  function automatic sdiclk_seq_t seq_step(input sdiclk_seq_t q, input logic ref_ok,
                                           input logic lock, input logic done);
    sdiclk_seq_t n;
    n = q;
    n.tmr = q.tmr + 16'h1;
    unique case (q.st)
      ST_POWERUP: begin
        if (q.tmr >= 16'(INIT_WAIT_CYC)) begin
          n.st = ST_ASSERT;
        end
      end
      ST_ASSERT: begin
        n.pll_rst  = 1'b1;
        n.chan_rst = 1'b1;
        n.full_req = 1'b0;
        n.tmr      = 16'h0;
        n.st       = ST_WAIT_REF;
      end
      ST_WAIT_REF: begin
        if (ref_ok) begin
          n.pll_rst = 1'b0;
          n.tmr     = 16'h0;
          n.st      = ST_WAIT_LOCK;
        end
      end
      ST_WAIT_LOCK: begin
        if (lock) begin
          n.chan_rst = 1'b0;
          n.tmr      = 16'h0;
          n.st       = ST_WAIT_DONE;
        end
      end
      ST_WAIT_DONE: begin
        if (done) begin
          n.st = ST_DONE;
        end
      end
      ST_TIMEOUT: begin
        n.retry = q.retry + 8'h1;
        n.st    = (q.retry + 8'h1 >= 8'(RETRIES)) ? ST_FAIL : ST_ASSERT;
      end
      ST_DONE: begin
        if (q.full_req) begin
          n.retry = 8'h0;
          n.st    = ST_ASSERT;
        end
      end
      ST_FAIL: begin
        if (q.full_req) begin
          n.retry = 8'h0;
          n.st    = ST_ASSERT;
        end
      end
    endcase
    if ((q.st == ST_WAIT_REF || q.st == ST_WAIT_LOCK || q.st == ST_WAIT_DONE)
        && n.st == q.st && q.tmr >= 16'(TIMEOUT - 1)) begin
      n.st = ST_TIMEOUT;
    end
    return n;
  endfunction

  // ============================================================
  // User-ready counters in the word-clock domains
  logic [1:0] rx_rst_w, tx_rst_w;
  logic [2:0] rx_cnt_r, tx_cnt_r;
  logic       rx_rdy_r, tx_rdy_r;

  always_ff @(posedge RX_USRCLK) begin
    rx_rst_w <= {rx_rst_w[0], s_r.rx.chan_rst};
    if (rx_rst_w[1]) begin
      rx_cnt_r <= 3'h0;
      rx_rdy_r <= 1'b0;
    end else if (rx_cnt_r < 3'(USRRDY_CYC - 1)) begin
      rx_cnt_r <= rx_cnt_r + 3'h1;
    end else begin
      rx_rdy_r <= 1'b1;
    end
  end

  always_ff @(posedge TX_USRCLK) begin
    tx_rst_w <= {tx_rst_w[0], s_r.tx.chan_rst};
    if (tx_rst_w[1]) begin
      tx_cnt_r <= 3'h0;
      tx_rdy_r <= 1'b0;
    end else if (tx_cnt_r < 3'(USRRDY_CYC - 1)) begin
      tx_cnt_r <= tx_cnt_r + 3'h1;
    end else begin
      tx_rdy_r <= 1'b1;
    end
  end

  // ============================================================
  // Next-state logic
  always_comb begin
    logic       slow;
    logic       ch_tx;
    logic       ch_rx;
    logic [1:0] rx_mode;
    logic [1:0] tx_mode;
    slow    = 1'b0;
    ch_tx   = 1'b0;
    ch_rx   = 1'b0;
    rx_mode = 2'h0;
    tx_mode = 2'h0;
    s_nxt   = s_r;

    // ============================================================
    // Status bits cross from transceiver clocks
    s_nxt.ref_rx_s = {s_r.ref_rx_s[0], RX_REFCLK_STABLE};
    s_nxt.ref_tx_s = {s_r.ref_tx_s[0], TX_REFCLK_STABLE};
    s_nxt.lk_sh_s  = {s_r.lk_sh_s[0], SHARED_PLL_LOCK};
    s_nxt.lk_ch_s  = {s_r.lk_ch_s[0], CHANNEL_PLL_LOCK};
    s_nxt.dn_rx_s  = {s_r.dn_rx_s[0], RX_RESET_DONE};
    s_nxt.dn_tx_s  = {s_r.dn_tx_s[0], TX_RESET_DONE};

    // Register port
    s_nxt.rdata = 32'h0;
    if (RD) begin
      unique case (ADDR)
        ADDR_CTRL:   s_nxt.rdata = s_r.ctrl;
        ADDR_RATE:   s_nxt.rdata = s_r.rate;
        ADDR_STATUS: s_nxt.rdata = {19'h0, s_r.tx_div, s_r.tx_sel, s_r.rx_sel,
                                    s_r.tx.st, s_r.rx.st};
        ADDR_RETRY:  s_nxt.rdata = {16'h0, s_r.tx.retry, s_r.rx.retry};
        default:     s_nxt.rdata = 32'h0;
      endcase
    end
    if (WR && ADDR == ADDR_CTRL) begin
      s_nxt.ctrl = {WDATA[31:2], 2'b00};
      // Full reset requests are held until the sequencer can take them
      if (WDATA[CTRL_RX_FULL]) s_nxt.rx.full_req = 1'b1;
      if (WDATA[CTRL_TX_FULL]) s_nxt.tx.full_req = 1'b1;
    end
    if (WR && ADDR == ADDR_RATE) begin
      s_nxt.rate = WDATA;
    end

    // Sequencers, run separately
    s_nxt.rx = seq_step(s_nxt.rx, s_r.ref_rx_s[1], s_r.lk_sh_s[1], s_r.dn_rx_s[1]);
    s_nxt.tx = seq_step(s_nxt.tx, s_r.ref_tx_s[1], s_r.lk_ch_s[1], s_r.dn_tx_s[1]);

    // ============================================================
    // Clock source selection
    slow    = s_r.ctrl[CTRL_SLOW_GRADE];
    rx_mode = s_r.rate[RATE_RX_MODE +: 2];
    tx_mode = s_r.rate[RATE_TX_MODE +: 2];
    // Receiver on shared PLL unless the slow grade forbids it or CTRL_RX_SEL selects the channel PLL
    ch_rx = slow | s_r.ctrl[CTRL_RX_SEL];
    // Transmitter follows the requested rate family
    ch_tx = slow | s_r.ctrl[CTRL_TX_SEL] | s_r.rate[RATE_TX_MULT];
    if (s_r.tx.st == ST_DONE) begin
      // Source and divider change only with the transmit channel held in reset
      if (s_r.tx_sel != (ch_tx ? SEL_CHANNEL : SEL_SHARED)
          || s_r.tx_div != div_for(tx_mode, ch_tx)) begin
        s_nxt.tx.full_req = 1'b1;
      end
    end
    if (s_r.tx.st == ST_ASSERT) begin
      s_nxt.tx_sel = ch_tx ? SEL_CHANNEL : SEL_SHARED;
      s_nxt.tx_div = div_for(tx_mode, ch_tx);
    end
    s_nxt.rx_sel = ch_rx ? SEL_CHANNEL : SEL_SHARED;

    // Receive divider via the configuration port
    s_nxt.dcp_en = 1'b0;
    // A source change alone also needs a new divider
    if ((s_r.rx_mode_app != rx_mode || s_r.dcp_di[2:0] != div_for(rx_mode, ch_rx))
        && !s_r.dcp_pend) begin
      s_nxt.dcp_pend = 1'b1;
    end
    // Never write while the receiver is about to enter reset
    if (s_r.dcp_pend && DCP_RDY && s_r.rx.st == ST_DONE
        && s_nxt.rx.st == ST_DONE) begin
      s_nxt.dcp_en      = 1'b1;
      s_nxt.dcp_di      = {13'h0, div_for(rx_mode, ch_rx)};
      s_nxt.rx_mode_app = rx_mode;
      s_nxt.dcp_pend    = 1'b0;
    end
  end

  // ============================================================
  // State register
  always_ff @(posedge SYS_CLK) begin
    if (!RSTN) begin
      s_r             <= '0;
      s_r.rx.st       <= ST_POWERUP;
      s_r.tx.st       <= ST_POWERUP;
      s_r.ctrl        <= CTRL_RESET;
      s_r.rx_sel      <= SEL_SHARED;
      s_r.tx_sel      <= SEL_SHARED;
      s_r.tx_div      <= DIV_BY_2;
      s_r.rx_mode_app <= 2'h0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ============================================================
  // Outputs
  assign RDATA             = s_r.rdata;
  assign SHARED_PLL_RESET  = s_r.rx.pll_rst;
  assign CHANNEL_PLL_RESET = s_r.tx.pll_rst;
  assign RX_CHAN_RESET     = s_r.rx.chan_rst;
  assign TX_CHAN_RESET     = s_r.tx.chan_rst;
  assign RX_USER_READY     = rx_rdy_r;
  assign TX_USER_READY     = tx_rdy_r;
  assign RX_PLL_SEL        = s_r.rx_sel;
  assign TX_PLL_SEL        = s_r.tx_sel;
  assign TX_DIV_SEL        = s_r.tx_div;
  assign DCP_EN            = s_r.dcp_en;
  assign DCP_WE            = s_r.dcp_en;
  assign DCP_ADDR          = DCP_ADDR_RXDIV;
  assign DCP_DI            = s_r.dcp_di;
endmodule

/* File: test/sdiclk_assertions.sv */
// Purpose: Port-level timing checks of the clock and reset controller
// Assumes: Word-clock checks run on the word clocks, the rest on SYS_CLK
// Notes:   Bound into every controller instance
module sdiclk_chk
  import sdiclk_pkg::*;
(
  input wire logic       SYS_CLK,
  input wire logic       RSTN,
  input wire logic       RX_REFCLK_STABLE,
  input wire logic       TX_REFCLK_STABLE,
  input wire logic       SHARED_PLL_LOCK,
  input wire logic       RX_USRCLK,
  input wire logic       TX_USRCLK,
  input wire logic       DCP_RDY,
  input wire logic       SHARED_PLL_RESET,
  input wire logic       CHANNEL_PLL_RESET,
  input wire logic       RX_CHAN_RESET,
  input wire logic       TX_CHAN_RESET,
  input wire logic       RX_USER_READY,
  input wire logic       TX_USER_READY,
  input wire logic [1:0] TX_PLL_SEL,
  input wire logic [2:0] TX_DIV_SEL,
  input wire logic       DCP_EN,
  input wire logic       DCP_WE,
  input wire logic [8:0] DCP_ADDR
);
  timeunit 1ns;
  timeprecision 100ps;
  // ============================================================
  // Cycles since reset release, saturating
  logic [5:0] cyc_r;
  always_ff @(posedge SYS_CLK) begin
    cyc_r <= !RSTN ? 6'h00 : cyc_r + 6'(cyc_r != 6'h3F);
  end
  a_reset_values: assert property (@(posedge SYS_CLK) !RSTN |=>
    !SHARED_PLL_RESET && !CHANNEL_PLL_RESET && !RX_CHAN_RESET && !TX_CHAN_RESET
    && TX_DIV_SEL == 3'h1) else $error("outputs not at reset values");
  a_init_wait: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
    $rose(SHARED_PLL_RESET) || $rose(CHANNEL_PLL_RESET) |-> cyc_r >= INIT_WAIT_CYC)
    else $error("PLL reset before power-up wait");
  a_rx_ref_first: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
    $fell(SHARED_PLL_RESET) |-> $past(RX_REFCLK_STABLE, 3)) else $error("shared PLL early");
  a_tx_ref_first: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
    $fell(CHANNEL_PLL_RESET) |-> $past(TX_REFCLK_STABLE, 3)) else $error("channel PLL early");
  a_lock_first: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
    $fell(RX_CHAN_RESET) |-> !SHARED_PLL_RESET && $past(SHARED_PLL_LOCK, 3))
    else $error("rx reset released before lock");
  a_tx_rdy_delay: assert property (@(posedge TX_USRCLK) disable iff (!RSTN)
    $fell(TX_CHAN_RESET) |-> !TX_USER_READY [*5] ##[1:4] TX_USER_READY)
    else $error("tx user ready timing");
  a_rx_rdy_delay: assert property (@(posedge RX_USRCLK) disable iff (!RSTN)
    $fell(RX_CHAN_RESET) |-> !RX_USER_READY [*5] ##[1:4] RX_USER_READY)
    else $error("rx user ready timing");
  a_dcp_write: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
    DCP_EN |-> DCP_WE && DCP_ADDR == DCP_ADDR_RXDIV ##1 !DCP_EN) else $error("bad port write");
  a_dcp_idle: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
    DCP_EN |-> $past(DCP_RDY) && !RX_CHAN_RESET) else $error("port write while busy");
  a_sel_in_reset: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
    $changed(TX_PLL_SEL) || $changed(TX_DIV_SEL) |-> TX_CHAN_RESET)
    else $error("tx clock changed outside reset");
endmodule

bind sdiclk_ctrl sdiclk_chk chk_u (.*);

/* File: test/sdiclk_xcvr.sv */
// Purpose: Behavioural transceiver channel and PLLs facing the controller
// Assumes: Locks need 8 clean cycles; reset done needs 4
// Notes:   hold_lock keeps the shared PLL unlocked to force timeouts
module sdiclk_xcvr (
  input  wire logic clk,
  input  wire logic sh_rst,
  input  wire logic ch_rst,
  input  wire logic rx_rst,
  input  wire logic tx_rst,
  input  wire logic dcp_en,
  input  wire logic hold_lock,
  output logic      sh_lock,
  output logic      ch_lock,
  output logic      rx_done,
  output logic      tx_done,
  output logic      rx_clk,
  output logic      tx_clk,
  output logic      dcp_rdy
);
  timeunit 1ns;
  timeprecision 100ps;
  // ============================================================
  logic [7:0] sh_r = 8'h00;
  logic [7:0] ch_r = 8'h00;
  logic [3:0] rxd_r = 4'h0;
  logic [3:0] txd_r = 4'h0;
  logic [3:0] dcp_r = 4'h0;
  initial begin
    rx_clk = 1'b0;
    forever #3.4 rx_clk = ~rx_clk;
  end
  initial begin
    tx_clk = 1'b0;
    forever #3.7 tx_clk = ~tx_clk;
  end
  always @(posedge clk) begin
    sh_r <= {sh_r[6:0], !sh_rst && !hold_lock};
    ch_r <= {ch_r[6:0], !ch_rst};
    rxd_r <= {rxd_r[2:0], !rx_rst && sh_lock};
    txd_r <= {txd_r[2:0], !tx_rst};
    dcp_r <= {dcp_r[2:0], dcp_en};
  end
  assign sh_lock = &sh_r;
  assign ch_lock = &ch_r;
  assign rx_done = &rxd_r;
  assign tx_done = &txd_r;
  // Port stays busy for four cycles after each write
  assign dcp_rdy = ~|dcp_r;
endmodule

/* File: test/sdiclk_ctrl_tb.sv */
// Purpose: Self-checking bench for the clock and reset controller
// Assumes: Shortened wait timeout of 50 cycles
// Notes:   Rate and source cases from a table, then reset and fault cases
module sdiclk_ctrl_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import sdiclk_pkg::*;
  `define CHK(n, e, s) begin samples_checked++; if ((s) !== (e)) begin num_errors++; \
    $display("FAIL %s exp %0h got %0h", n, e, s); end end
  typedef struct packed {logic [4:0] ctl; logic [4:0] rate; logic [1:0] ts;
    logic [2:0] td; logic [1:0] rs; logic [2:0] rdv;} sdiclk_row_t;
  sdiclk_row_t rows [7] = '{'{5'h00, 5'h05, 2'h3, 3'h2, 2'h3, 3'h2},
    '{5'h00, 5'h0A, 2'h3, 3'h1, 2'h3, 3'h1}, '{5'h00, 5'h00, 2'h3, 3'h1, 2'h3, 3'h1},
    '{5'h08, 5'h05, 2'h0, 3'h1, 2'h3, 3'h2}, '{5'h0C, 5'h0A, 2'h0, 3'h0, 2'h0, 3'h0},
    '{5'h10, 5'h05, 2'h0, 3'h1, 2'h0, 3'h1}, '{5'h00, 5'h15, 2'h0, 3'h1, 2'h3, 3'h2}};
  int num_errors = 0;
  int samples_checked = 0;
  logic sys_clk = 0, rstn = 0, wr = 0, rd = 0, rx_ref = 1, tx_ref = 1, hold = 0;
  logic [3:0] addr = 4'h0;
  logic [31:0] wdata = 32'h0, rdata, v;
  logic rxl, txl, rxd, txd, rxc, txc, drdy, spr, cpr, rxr, txr, rxu, txu, den, dwe;
  logic [1:0] rxs, txs;
  logic [2:0] tdv;
  logic [8:0] dad;
  logic [15:0] ddi, last_di = 16'hXXXX;
  sdiclk_ctrl #(.TIMEOUT(50), .RETRIES(MAX_RETRIES)) dut_u (.SYS_CLK(sys_clk), .RSTN(rstn),
    .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata), .RX_REFCLK_STABLE(rx_ref),
    .TX_REFCLK_STABLE(tx_ref), .SHARED_PLL_LOCK(rxl), .CHANNEL_PLL_LOCK(txl),
    .RX_RESET_DONE(rxd), .TX_RESET_DONE(txd), .RX_USRCLK(rxc), .TX_USRCLK(txc),
    .DCP_RDY(drdy), .SHARED_PLL_RESET(spr), .CHANNEL_PLL_RESET(cpr), .RX_CHAN_RESET(rxr),
    .TX_CHAN_RESET(txr), .RX_USER_READY(rxu), .TX_USER_READY(txu), .RX_PLL_SEL(rxs),
    .TX_PLL_SEL(txs), .TX_DIV_SEL(tdv), .DCP_EN(den), .DCP_WE(dwe), .DCP_ADDR(dad),
    .DCP_DI(ddi));
  sdiclk_xcvr xcvr_u (.clk(sys_clk), .sh_rst(spr), .ch_rst(cpr), .rx_rst(rxr), .tx_rst(txr),
    .dcp_en(den), .hold_lock(hold), .sh_lock(rxl), .ch_lock(txl), .rx_done(rxd),
    .tx_done(txd), .rx_clk(rxc), .tx_clk(txc), .dcp_rdy(drdy));
  // ============================================================
  initial forever #10 sys_clk = ~sys_clk;
  always @(posedge sys_clk) if (den === 1'b1) last_di <= ddi;
  task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge sys_clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [3:0] a, output logic [31:0] d);
    @(posedge sys_clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge sys_clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic wait_done(input logic [5:0] st);
    for (int i = 0; i < 300; i++) begin
      rd_reg(ADDR_STATUS, v);
      if (v[5:0] === st) break;
    end
    `CHK("state", st, v[5:0])
  endtask
  task automatic power_up();
    @(posedge sys_clk);
    rstn <= 1'b0;
    repeat (16) @(posedge sys_clk);
    #1 `CHK("in_reset", 6'h19, {spr | cpr | rxr | txr, rxs, tdv})
    @(posedge sys_clk);
    rstn <= 1'b1;
    wait_done(6'h36);
    `CHK("user_rdy", 2'h3, {rxu, txu})
  endtask
  task automatic print_verdict();
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (30000) @(posedge sys_clk);
    num_errors++;
    print_verdict();
  end
  initial begin
    power_up();
    foreach (rows[i]) begin
      wr_reg(ADDR_CTRL, 32'(rows[i].ctl));
      wr_reg(ADDR_RATE, 32'(rows[i].rate));
      wait_done(6'h36);
      wr_reg(ADDR_CTRL, 32'(rows[i].ctl));
      wait_done(6'h36);
      `CHK("tx_sel", rows[i].ts, txs)
      `CHK("tx_div", rows[i].td, tdv)
      `CHK("rx_sel", rows[i].rs, rxs)
      `CHK("rx_div", rows[i].rdv, last_di[2:0])
      `CHK("status", {rows[i].td, rows[i].ts, rows[i].rs}, v[12:6])
    end
    wr_reg(4'hF, 32'hFFFF_FFFF);
    rd_reg(4'hF, v);
    `CHK("unmapped", 32'h0, v)
    tx_ref <= 1'b0;
    wr_reg(ADDR_CTRL, 32'h0000_0002);
    rd_reg(ADDR_CTRL, v);
    `CHK("ctrl", 32'h0, v)
    repeat (30) @(posedge sys_clk);
    #1 `CHK("ch_pll_rst", 2'h3, {cpr, txr})
    tx_ref <= 1'b1;
    wait_done(6'h36);
    hold <= 1'b1;
    wr_reg(ADDR_CTRL, 32'h0000_0001);
    wait_done(6'h37);
    rd_reg(ADDR_RETRY, v);
    `CHK("retries", 8'(MAX_RETRIES), v[7:0])
    hold <= 1'b0;
    wr_reg(ADDR_CTRL, 32'h0000_0001);
    wait_done(6'h36);
    power_up();
    print_verdict();
  end
endmodule
